/* bench/tb_thc_top.sv */
// self-checking bench for the thermocouple channel image logic
`default_nettype none

module tb_thc_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               core_clk    = 1'b0;
    logic               rst_b       = 1'b0;
    logic               img_wr      = 1'b0;
    logic        [1:0]  img_wr_idx  = 2'h0;
    logic        [15:0] img_wr_data = 16'h0000;
    logic        [2:0]  img_rd_idx  = 3'h0;
    logic        [15:0] img_rd_data, scan_setup;
    logic signed [16:0] ain_value, val = 17'sh0;
    logic               ain_open, scan_busy, rd_go = 1'b0, rd_q = 1'b0;
    logic        [1:0]  cjs_present, scan_ch, cjs_in = 2'h3;
    logic        [3:0]  open_mask = 4'h0;
    logic        [15:0] exp_q [$];
    int                 bad_count = 0, n_compared = 0, seed = 21528, rv;

    always #5 core_clk = ~core_clk;

    // short counts keep the run small; ordering of update times kept
    thc_top #(.OC_FLAG_CYC(20), .UPD_CYC_F10(40), .UPD_CYC_F50(24), .UPD_CYC_F60(20), .UPD_CYC_F250(10))
    thc_top_inst (.core_clk, .rst_b, .img_wr, .img_wr_idx, .img_wr_data, .img_rd_idx, .img_rd_data,
                  .ain_value, .ain_open, .cjs_present, .scan_busy, .scan_ch, .scan_setup);
    thc_fe_model thc_fe_model_inst (.scan_busy, .scan_ch, .val, .open_mask, .cjs_in, .ain_value,
                                    .ain_open, .cjs_present);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude;
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [1:0] ch, input logic [15:0] w);
        img_wr      = 1'b1;
        img_wr_idx  = ch;
        img_wr_data = w & 16'h0fff;
        @(posedge core_clk);
        #1;
        img_wr      = 1'b0;
    endtask : wr

    // note the expectation; the monitor compares one cycle after the index is taken
    task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
        img_rd_idx = idx;
        exp_q.push_back(exp);
        rd_go = 1'b1;
        @(posedge core_clk);
        #1;
        rd_go = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : rd

    // returns just after the edge that updates channel ch
    task automatic wait_upd(input logic [1:0] ch);
        logic wb = 1'b0;
        int   n;
        for (n = 0; n < 500; n++)
        begin
            @(posedge core_clk);
            #1;
            if (wb && !scan_busy && scan_ch === ch)
                break;
            wb = scan_busy;
        end
        if (n == 500)
            cmp(16'hdead, 16'h0000);
        @(posedge core_clk);
        #1;
    endtask : wait_upd

    // four updates outlast the open-circuit hold time
    task automatic row(input logic [15:0] w, input int v, input logic op, input logic [1:0] cj,
                       input logic [15:0] ed, input logic [3:0] hi);
        val       = 17'(v);
        open_mask = {2'h0, op, 1'b0};
        cjs_in    = cj;
        wr(2'h1, w);
        repeat (4) wait_upd(2'h1);
        rd(3'h1, ed);
        rd(3'h5, {hi, w[11:0]});
    endtask : row

    task automatic dwell(input logic [15:0] w, input logic [15:0] exp);
        int n;
        wr(2'h1, w);
        wait_upd(2'h1);
        for (n = 0; n < 500 && !scan_busy; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        cmp(scan_setup, w);
        n = 0;
        while (scan_busy && n < 500)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        cmp(16'(n), exp);
    endtask : dwell
    // ------------------------------------------------------------
    // monitor, watchdog and sequence
    // ------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (rd_q)
            cmp(img_rd_data, exp_q.pop_front());
        rd_q <= rd_go;
    end

    initial
    begin
        #200000;
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++)
            rd(3'(i), 16'h0000);
        rv = $random(seed) % 5000;
        wr(2'h1, 16'h0e00);
        rd(3'h1, 16'h0000);
        rd(3'h5, 16'h0000);
        row(16'h0e00, 500, 1'b1, 2'h3, 16'h0000, 4'h1);
        row(16'h0e40, 500, 1'b1, 2'h3, 16'h1db0, 4'h1);
        row(16'h0e80, 500, 1'b1, 2'h3, 16'hf7cc, 4'h1);
        row(16'h0e01, 500, 1'b0, 2'h1, 16'h0000, 4'h1);
        row(16'h0e08, rv, 1'b0, 2'h1, 16'(rv), 4'h0);
        row(16'h0f08, rv, 1'b0, 2'h1, 16'(rv), 4'h0);
        row(16'h0f06, 40000 - rv, 1'b0, 2'h3, 16'h7fff, 4'h4);
        row(16'h0e00, 500, 1'b0, 2'h3, 16'h01f4, 4'h0);
        row(16'h0e20, -5, 1'b0, 2'h3, 16'h0000, 4'h2);
        row(16'h0e30, 40000, 1'b0, 2'h3, 16'h7fff, 4'h4);
        row(16'h0ec0, 500, 1'b0, 2'h3, 16'h0000, 4'h8);
        row(16'h0e0a, 500, 1'b0, 2'h3, 16'h0000, 4'h8);
        dwell(16'h0800, 16'd40);
        dwell(16'h0a00, 16'd24);
        dwell(16'h0c00, 16'd20);
        dwell(16'h0e00, 16'd10);
        dwell(16'h080f, 16'd10);
        wr(2'h1, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1;
        rd(3'h1, 16'h0000);
        rd(3'h5, 16'h0000);
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule : tb_thc_top

`default_nettype wire

/* bench/thc_fe_model.sv */
// front-end model: converted reading, open wire and junction sensors
`default_nettype none

module thc_fe_model (
    input  wire logic               scan_busy,
    input  wire logic [1:0]         scan_ch,
    input  wire logic signed [16:0] val,
    input  wire logic [3:0]         open_mask,
    input  wire logic [1:0]         cjs_in,
    output logic signed [16:0]      ain_value,
    output logic                    ain_open,
    output logic [1:0]              cjs_present
);
    timeunit 1ns;
    timeprecision 1ns;
    // readings hold only while sampled; scrambled during conversion so a stale look fails
    assign ain_value   = scan_busy ? ~val : val;
    assign ain_open    = scan_busy ? ~open_mask[scan_ch] : open_mask[scan_ch];
    // sensor presence is a plain level from the terminals
    assign cjs_present = cjs_in;
endmodule : thc_fe_model

`default_nettype wire

/* hdl/thc_oc_if.sv */
// open-circuit timing link between the scanner and one channel timer
`default_nettype none

interface thc_oc_if;
    logic upd;       // channel update strobe
    logic raw_open;  // open sensed at this update
    logic clr;       // channel disabled
    logic flag;      // open circuit is to be reported now

    modport seq (output upd, output raw_open, output clr, input flag);
    modport tmr (input upd, input raw_open, input clr, output flag);
endinterface : thc_oc_if

`default_nettype wire

/* hdl/thc_oc_timer.sv */
// per-channel open-circuit hold timer
`default_nettype none

module thc_oc_timer #(
    parameter int unsigned FLAG_CYC = 32'd50_000_000
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    thc_oc_if.tmr     oc
);
    import thc_pkg::*;

    logic        open_seen;
    logic [31:0] cnt;
    logic        sat;

    assign sat = (cnt >= FLAG_CYC);

    // open state follows the raw sense taken at each update
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || oc.clr)
            open_seen <= 1'b0;
        else if (oc.upd)
            open_seen <= oc.raw_open;
    end

    // time since the open was first seen, saturating
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || oc.clr || !open_seen)
            cnt <= 32'h0000_0000;
        else if (!sat)
            cnt <= cnt + 32'h0000_0001;
    end

    // report only at a later update once the hold has run out, so the
    // longer of hold time and one update wins; data may ramp until then
    assign oc.flag = oc.raw_open && open_seen && sat;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_no_early_flag: assert property ($rose(open_seen) |-> !oc.flag [*8])
        else $error("open flag raised right after first detection");

endmodule : thc_oc_timer

`default_nettype wire

/* hdl/thc_pkg.sv */
// shared constants and types for the thermocouple channel image logic
`default_nettype none

package thc_pkg;

    // ------------------------------------------------------------
    // image layout
    // ------------------------------------------------------------
    localparam int         N_CH      = 4;
    localparam logic [2:0] COND_BASE = 3'h4;  // condition words follow data words

    // ------------------------------------------------------------
    // setup and condition word fields
    // ------------------------------------------------------------
    localparam int          TYPE_LSB   = 0;
    localparam int          FMT_LSB    = 4;
    localparam int          OCR_LSB    = 6;
    localparam int          UNITS_BIT  = 8;
    localparam int          FILT_LSB   = 9;
    localparam int          EN_BIT     = 11;
    localparam int          OPEN_BIT   = 12;
    localparam int          UNDER_BIT  = 13;
    localparam int          OVER_BIT   = 14;
    localparam int          CFGERR_BIT = 15;
    localparam logic [15:0] SETUP_MASK = 16'h0fff;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    // ------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_B     = 4'h6;
    localparam logic [3:0] TYPE_MV50  = 4'h8;
    localparam logic [3:0] TYPE_MV100 = 4'h9;
    localparam logic [3:0] TYPE_CJC   = 4'hf;
    localparam logic [1:0] FMT_X1     = 2'h0;
    localparam logic [1:0] FMT_PID    = 2'h2;
    localparam logic [1:0] FMT_CNT    = 2'h3;
    localparam logic [1:0] OCR_ZERO   = 2'h0;
    localparam logic [1:0] OCR_UP     = 2'h1;
    localparam logic [1:0] OCR_DOWN   = 2'h2;
    localparam logic [1:0] OCR_BAD    = 2'h3;
    localparam logic [1:0] FILT_10    = 2'h0;
    localparam logic [1:0] FILT_50    = 2'h1;
    localparam logic [1:0] FILT_60    = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ     = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int OC_FLAG_MS = 500;
    // lower filter frequency, longer channel update
    localparam int UPD_MS_F10  = 200;
    localparam int UPD_MS_F50  = 48;
    localparam int UPD_MS_F60  = 40;
    localparam int UPD_MS_F250 = 12;

    // low and full scale of one input type and data format
    typedef struct packed {
        logic signed [16:0] lo;
        logic signed [16:0] hi;
    } thc_range_s;

endpackage : thc_pkg

`default_nettype wire

/* hdl/thc_top.sv */
// four-channel thermocouple setup, data and condition image logic
//
// Contract
// - open-circuit field picks reported data word
// - missing junction sensor opens non-millivolt channels
// - zero response forces data word to zero
// - upscale response gives full-scale value
// - downscale response gives low-scale value
// - flag open after both hold and an update
// - units bit ignored for millivolt inputs
// - over-range beyond representable top value
// - filter field sets channel update time
// - four filters: 10, 50, 60, 250
// - lower filter means longer update
// - filter ignored for junction-sensor input
// - scan only enabled channels
// - setup change while enabled restarts update
// - disabled channel reads zero until updated
// - data words at image words 0-3
// - condition words at image words 4-7
// - condition echoes accepted setup and errors
`default_nettype none

module thc_top #(
    parameter int unsigned OC_FLAG_CYC  = thc_pkg::OC_FLAG_MS * thc_pkg::CYC_PER_MS,
    parameter int unsigned UPD_CYC_F10  = thc_pkg::UPD_MS_F10 * thc_pkg::CYC_PER_MS,
    parameter int unsigned UPD_CYC_F50  = thc_pkg::UPD_MS_F50 * thc_pkg::CYC_PER_MS,
    parameter int unsigned UPD_CYC_F60  = thc_pkg::UPD_MS_F60 * thc_pkg::CYC_PER_MS,
    parameter int unsigned UPD_CYC_F250 = thc_pkg::UPD_MS_F250 * thc_pkg::CYC_PER_MS
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                img_wr,       // setup word write strobe
    input  wire logic [1:0]          img_wr_idx,
    input  wire logic [15:0]         img_wr_data,
    input  wire logic [2:0]          img_rd_idx,
    output logic      [15:0]         img_rd_data,
    input  wire logic signed [16:0]  ain_value,    // reading of scan_ch in its format
    input  wire logic                ain_open,     // open wire sensed on scan_ch
    input  wire logic [1:0]          cjs_present,  // one bit per junction sensor
    output logic                     scan_busy,
    output logic      [1:0]          scan_ch,
    output logic      [15:0]         scan_setup
);
    import thc_pkg::*;

    typedef enum logic {SQ_IDLE, SQ_DWELL} thc_seq_e;

    thc_seq_e              state;
    logic [15:0]           setup [N_CH];
    logic [N_CH-1:0][15:0] data_bus;
    logic [N_CH-1:0][15:0] cond_bus;
    logic [31:0]           dwell;
    logic [N_CH-1:0]       upd;
    logic [1:0]            next_ch;
    logic [1:0]            cand;
    logic                  next_found;
    logic                  same_cfg;
    logic                  end_hit;
    logic                  cjs_lost;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // scale limits per input type, data format and units
    function automatic thc_range_s scale_of(input logic [3:0] ty,
                                            input logic [1:0] fmt,
                                            input logic       fahr);
        int         lo;
        int         hi;
        thc_range_s r;
        lo = 0;
        hi = 0;
        // base limits, multiplied by ten for FMT_X1 except type B Fahrenheit high and CJC Fahrenheit low; millivolt rows ignore units
        case (ty)
            4'h0: {lo, hi} = fahr ? {-32'sd346, 32'sd1400} : {-32'sd210, 32'sd760};
            4'h1: {lo, hi} = fahr ? {-32'sd454, 32'sd2498} : {-32'sd270, 32'sd1370};
            4'h2: {lo, hi} = fahr ? {-32'sd454, 32'sd752} : {-32'sd270, 32'sd400};
            4'h3: {lo, hi} = fahr ? {-32'sd454, 32'sd1832} : {-32'sd270, 32'sd1000};
            4'h4: {lo, hi} = fahr ? {32'sd32, 32'sd3214} : {32'sd0, 32'sd1768};
            4'h5: {lo, hi} = fahr ? {32'sd32, 32'sd3214} : {32'sd0, 32'sd1768};
            4'h6: {lo, hi} = fahr ? {32'sd572, 32'sd3308} : {32'sd300, 32'sd1820};
            4'h7: {lo, hi} = fahr ? {32'sd32, 32'sd2372} : {32'sd0, 32'sd1300};
            4'h8: {lo, hi} = {-32'sd500, 32'sd500};
            4'h9: {lo, hi} = {-32'sd1000, 32'sd1000};
            4'hf: {lo, hi} = fahr ? {32'sd32, 32'sd185} : {32'sd0, 32'sd85};
            default: {lo, hi} = {32'sd0, 32'sd0};
        endcase
        if (fmt == FMT_X1)
        begin
            // type b in tenths of Fahrenheit tops out at the 15-bit limit
            if (ty == TYPE_B && fahr)
                hi = 32767;
            else
                hi = hi * 10;
            if (!(ty == TYPE_CJC && fahr))
                lo = lo * 10;
        end
        else if (fmt == FMT_PID)
        begin
            lo = 0;
            hi = 16383;
        end
        else if (fmt == FMT_CNT)
        begin
            lo = -32768;
            hi = 32767;
        end
        r.lo = 17'(lo);
        r.hi = 17'(hi);
        return r;
    endfunction : scale_of

    // millivolt types take no temperature units
    function automatic logic is_mv(input logic [3:0] ty);
        return (ty == TYPE_MV50) || (ty == TYPE_MV100);
    endfunction : is_mv

    // channel update time from the filter field
    function automatic logic [31:0] dwell_of(input logic [15:0] w);
        if (w[TYPE_LSB +: 4] == TYPE_CJC)
            return 32'(UPD_CYC_F250);
        case (w[FILT_LSB +: 2])
            FILT_10: return 32'(UPD_CYC_F10);
            FILT_50: return 32'(UPD_CYC_F50);
            FILT_60: return 32'(UPD_CYC_F60);
            default: return 32'(UPD_CYC_F250);
        endcase
    endfunction : dwell_of

    // ------------------------------------------------------------
    // setup words
    // ------------------------------------------------------------

    // controller writes one setup word per channel
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int k = 0; k < N_CH; k++)
                setup[k] <= WORD_RST;
        end
        else if (img_wr)
            setup[img_wr_idx] <= img_wr_data;
    end

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------

    // next enabled channel after the current one, current one last
    always_comb
    begin
        next_found = 1'b0;
        next_ch    = scan_ch;
        cand       = scan_ch;
        for (int k = N_CH; k >= 1; k--)
        begin
            cand = 2'(int'(scan_ch) + k);
            if (setup[cand][EN_BIT])
            begin
                next_found = 1'b1;
                next_ch    = cand;
            end
        end
    end

    // upper bits are never looked at, the controller keeps them clear
    assign same_cfg = (setup[scan_ch] & SETUP_MASK) == scan_setup;
    assign end_hit  = (state == SQ_DWELL) && setup[scan_ch][EN_BIT] && same_cfg && (dwell == 32'h0000_0001);

    // one channel is converted at a time; a single idle cycle separates them
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state      <= SQ_IDLE;
            scan_ch    <= 2'h0;
            scan_setup <= WORD_RST;
            dwell      <= 32'h0000_0000;
            scan_busy  <= 1'b0;
        end
        else
        begin
            case (state)
                SQ_IDLE:
                begin
                    if (next_found)
                    begin
                        scan_ch    <= next_ch;
                        scan_setup <= setup[next_ch] & SETUP_MASK;
                        dwell      <= dwell_of(setup[next_ch]);
                        scan_busy  <= 1'b1;
                        state      <= SQ_DWELL;
                    end
                end
                SQ_DWELL:
                begin
                    if (!setup[scan_ch][EN_BIT])
                    begin
                        scan_busy <= 1'b0;
                        state     <= SQ_IDLE;
                    end
                    else if (!same_cfg)
                    begin
                        // restarting costs up to one update but never mixes configurations
                        scan_setup <= setup[scan_ch] & SETUP_MASK;
                        dwell      <= dwell_of(setup[scan_ch]);
                    end
                    else if (dwell == 32'h0000_0001)
                    begin
                        scan_busy <= 1'b0;
                        state     <= SQ_IDLE;
                    end
                    else
                        dwell <= dwell - 32'h0000_0001;
                end
                default: state <= SQ_IDLE;
            endcase
        end
    end

    // update strobe lands in the idle cycle while scan_ch still names the channel
    always_ff @(posedge core_clk)
    begin
        for (int k = 0; k < N_CH; k++)
            upd[k] <= rst_b && end_hit && (scan_ch == 2'(k));
    end

    assign cjs_lost = (cjs_present != 2'h3);

    // ------------------------------------------------------------
    // per-channel data and condition words
    // ------------------------------------------------------------
    for (genvar c = 0; c < N_CH; c++)
    begin : g_ch
        thc_oc_if          oc ();
        thc_range_s        rng;
        thc_range_s        crng;
        logic [15:0]       data;
        logic [15:0]       cond;
        logic [15:0]       next_data;
        logic              cfg_bad;
        logic              over;
        logic              under;

        assign cfg_bad = (scan_setup[TYPE_LSB +: 4] inside {[4'ha:4'he]})
                       || (scan_setup[OCR_LSB +: 2] == OCR_BAD);
        // fahrenheit only when the bit is one and the input is a temperature
        assign rng = scale_of(scan_setup[TYPE_LSB +: 4], scan_setup[FMT_LSB +: 2],
                              scan_setup[UNITS_BIT] && !is_mv(scan_setup[TYPE_LSB +: 4]));
        // limits of the configuration this channel last accepted
        assign crng = scale_of(cond[TYPE_LSB +: 4], cond[FMT_LSB +: 2],
                               cond[UNITS_BIT] && !is_mv(cond[TYPE_LSB +: 4]));

        // a lost junction sensor opens every temperature channel
        assign oc.raw_open = ain_open || (cjs_lost && !is_mv(scan_setup[TYPE_LSB +: 4]));
        assign oc.upd      = upd[c];
        assign oc.clr      = !setup[c][EN_BIT];

        thc_oc_timer #(
            .FLAG_CYC (OC_FLAG_CYC)
        ) u_oc (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .oc       (oc)
        );

        // reported value: forced on open, clamped at the scale limits
        always_comb
        begin
            over      = 1'b0;
            under     = 1'b0;
            next_data = ain_value[15:0];
            if (cfg_bad)
                next_data = WORD_RST;
            else if (oc.flag)
            begin
                case (scan_setup[OCR_LSB +: 2])
                    OCR_ZERO: next_data = WORD_RST;
                    OCR_UP:   next_data = rng.hi[15:0];
                    OCR_DOWN: next_data = rng.lo[15:0];
                    default:  next_data = WORD_RST;
                endcase
            end
            else if (ain_value > rng.hi)
            begin
                over      = 1'b1;
                next_data = rng.hi[15:0];
            end
            else if (ain_value < rng.lo)
            begin
                under     = 1'b1;
                next_data = rng.lo[15:0];
            end
        end

        // disabled channels read zero, and stay zero until the first update
        always_ff @(posedge core_clk)
        begin
            if (!rst_b || !setup[c][EN_BIT])
            begin
                data <= WORD_RST;
                cond <= WORD_RST;
            end
            else if (upd[c])
            begin
                data <= next_data;
                cond <= {cfg_bad, over, under, oc.flag && !cfg_bad, 1'b1, scan_setup[10:0]};
            end
        end

        assign data_bus[c] = data;
        assign cond_bus[c] = cond;

        chk_disabled_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
            !setup[c][EN_BIT] |=> (data == WORD_RST) && (cond == WORD_RST))
            else $error("disabled channel word not zero");
        chk_zero_fill: assert property (@(posedge core_clk) disable iff (!rst_b)
            cond[OPEN_BIT] && (cond[OCR_LSB +: 2] == OCR_ZERO) |-> data == WORD_RST)
            else $error("zero response not applied");
        chk_upscale_fill: assert property (@(posedge core_clk) disable iff (!rst_b)
            cond[OPEN_BIT] && (cond[OCR_LSB +: 2] == OCR_UP) |-> data == crng.hi[15:0])
            else $error("upscale response not full scale");
        chk_downscale_fill: assert property (@(posedge core_clk) disable iff (!rst_b)
            cond[OPEN_BIT] && (cond[OCR_LSB +: 2] == OCR_DOWN) |-> data == crng.lo[15:0])
            else $error("downscale response not low scale");
        chk_over_clamp: assert property (@(posedge core_clk) disable iff (!rst_b)
            cond[OVER_BIT] |-> !cond[OPEN_BIT] && (data == crng.hi[15:0]))
            else $error("over-range word not at full scale");
        chk_cond_echo: assert property (@(posedge core_clk) disable iff (!rst_b)
            upd[c] && setup[c][EN_BIT] |=> cond[EN_BIT] && (cond[10:0] == $past(scan_setup[10:0])))
            else $error("condition word does not echo setup");
        cov_open_flag: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(cond[OPEN_BIT]));
        cov_over_range: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(cond[OVER_BIT]));
    end

    // ------------------------------------------------------------
    // input image read
    // ------------------------------------------------------------

    // words 0-3 carry data, words 4-7 the condition of the same channels
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            img_rd_data <= WORD_RST;
        else if (img_rd_idx < COND_BASE)
            img_rd_data <= data_bus[img_rd_idx[1:0]];
        else
            img_rd_data <= cond_bus[img_rd_idx[1:0]];
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_scan_enabled: assert property ($rose(scan_busy) |-> scan_setup[EN_BIT])
        else $error("disabled channel scanned");
    chk_data_map: assert property ((img_rd_idx == 3'h0) |=> img_rd_data == $past(data_bus[0]))
        else $error("word 0 is not channel 0 data");
    chk_cond_map: assert property ((img_rd_idx == 3'h7) |=> img_rd_data == $past(cond_bus[3]))
        else $error("word 7 is not channel 3 condition");
    cov_cfg_restart: cover property ((state == SQ_DWELL) && setup[scan_ch][EN_BIT] && !same_cfg);

endmodule : thc_top

`default_nettype wire
